// file: common/link_map.svh
// Overview of operation
// - Host keeps one-time address bits 23..10 zero
// - One-time program needs write enable first
// - Zeros into locked region fail with error
// - One-time program only clears bits
// - Host sends ones to keep other bits
// - One-time read uses one dummy byte
// - One-time read never wraps past top
// - Config read low byte first, repeats
// - Sample on rising, drive on falling
// - Config program two bytes, select then
// - Select rise starts timed busy operation
// - Completion clears the write enable latch
// - Protection writes act like array program
// - Dynamic lock read repeats same byte
// - Dynamic lock write, one byte, select
// - Persistent lock read repeats same byte
// - Persistent program, address only, select
// - Persistent erase sets all bits one
// - Erase needs select after instruction
// - Suspend refused during persistent erase
// Purpose: Constants shared by both ends of the serial link
// Assumes: Mode 0 serial clock, 8-bit opcodes
// Notes:   Opcodes, counts and field positions
`ifndef LINK_MAP_SVH
`define LINK_MAP_SVH
`define OP_WRITE_ENABLE    8'h06
`define OP_STATUS_READ     8'h05
`define OP_CLEAR_STATUS    8'h30
`define OP_SUSPEND         8'h75
`define OP_ONE_TIME_PROG   8'h42
`define OP_ONE_TIME_READ   8'h4B
`define OP_CONFIG_READ     8'h2B
`define OP_CONFIG_PROG     8'h2F
`define OP_DYN_READ        8'hE0
`define OP_DYN_WRITE       8'hE1
`define OP_PERS_READ       8'hE2
`define OP_PERS_PROG       8'hE3
`define OP_PERS_ERASE      8'hE4
`define OTP_BYTES          1024
`define SECTORS            64
`define SECT_HI            23
`define SECT_LO            18
`define CONFIG_RESET       16'hFFFF
`define PROG_CYCLES        16'h0014
`define ERASE_CYCLES       16'h0064
`define SR_BUSY_BIT        0
`define SR_LATCH_BIT       1
`define SR_ERR_BIT         6
`define BITS_ONE_BYTE      16'h0008
`define BITS_CONFIG_PROG   16'h0018
`define BITS_PERS_PROG     16'h0028
`define BITS_DYN_WRITE     16'h0030
`define SCK_HALF           4'h8
`define REG_CMD            2'h0
`define REG_ADDR           2'h1
`define REG_WDATA          2'h2
`define REG_STATUS         2'h3
`define CMD_ABYTES_LSB     8
`define CMD_WBYTES_LSB     12
`define CMD_RBYTES_LSB     16
`define CMD_DUMMY_BIT      20
`define STAT_BUSY_BIT      31
`endif

// file: common/link_pkg.sv
// Purpose: Types shared by both ends
// Assumes: Constants come from link_map.svh
// Notes:   Host sequencer states
package link_pkg;
  typedef enum logic [4:0] {
    H_IDLE  = 5'b00001,
    H_LEAD  = 5'b00010,
    H_SHIFT = 5'b00100,
    H_TAIL  = 5'b01000,
    H_GAP   = 5'b10000
  } host_state_t;
endpackage

// file: common/spi_link_if.sv
// Purpose: Serial link between host and flash end
// Assumes: Single-bit data in each direction
// Notes:   No clocking block
`timescale 1ns/1ps
interface spi_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  modport device (input cs_n, input sck, input mosi, output miso);
  modport host   (output cs_n, output sck, output mosi, input miso);
endinterface

// file: hw/flash_protect_device.sv
// Purpose: One-time region and sector protection command handling
// Assumes: Link pins are asynchronous and oversampled by clk
// Notes:   Memories reset to erased state
`timescale 1ns/1ps
`include "link_map.svh"
module flash_protect_device
  import link_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        otp_locked,
  spi_link_if.device       link,
  output logic             in_progress_flag,
  output logic             write_enable_latch,
  output logic             program_error,
  output logic [15:0]      protect_config_register
);
  logic [2:0]  cs_s;
  logic [2:0]  sck_s;
  logic [1:0]  mosi_s;
  logic [15:0] bit_cnt;
  logic [6:0]  rx;
  logic [7:0]  opcode;
  logic [31:0] addr;
  logic [15:0] wbuf;
  logic [10:0] ptr;
  logic [7:0]  tx;
  logic        miso_q;
  logic        otp_err;
  logic [15:0] busy_cnt;
  logic        erasing;
  logic [7:0]  otp_mem [0:`OTP_BYTES-1];
  logic [`SECTORS-1:0] dynamic_sector_lock;
  logic [`SECTORS-1:0] persistent_sector_lock;
  logic        sck_rise;
  logic        sck_fall;
  logic        cs_rise;
  logic        cs_low;
  logic        mosi_bit;
  logic [15:0] next_cnt;
  logic        byte_done;
  logic [12:0] byte_no;
  logic [7:0]  byte_val;
  logic [5:0]  sect_now;
  logic        idle;
  logic        exec_ok;
  logic        otp_wr;

  function automatic logic [7:0] lock_byte(input logic b);
    lock_byte = b ? 8'hFF : 8'h00;
  endfunction

  function automatic logic [7:0] status_byte(input logic busy,
                                             input logic latch,
                                             input logic err);
    status_byte = 8'h00;
    status_byte[`SR_BUSY_BIT]  = busy;
    status_byte[`SR_LATCH_BIT] = latch;
    status_byte[`SR_ERR_BIT]  = err;
  endfunction

  // Pin synchronisers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_s   <= 3'b111;
      sck_s  <= 3'b000;
      mosi_s <= 2'b00;
    end else begin
      cs_s   <= {cs_s[1:0], link.cs_n};
      sck_s  <= {sck_s[1:0], link.sck};
      mosi_s <= {mosi_s[0], link.mosi};
    end
  end

  assign sck_rise  = sck_s[1] & ~sck_s[2];
  assign sck_fall  = ~sck_s[1] & sck_s[2];
  assign cs_rise   = cs_s[1] & ~cs_s[2];
  assign cs_low    = ~cs_s[1];
  assign mosi_bit  = mosi_s[1];
  assign next_cnt  = bit_cnt + 16'h0001;
  assign byte_done = sck_rise & cs_low & (next_cnt[2:0] == 3'h0);
  assign byte_no   = next_cnt[15:3];
  assign byte_val  = {rx, mosi_bit};
  assign sect_now  = (byte_no == 13'h0005) ? addr[15:10]
                                           : addr[`SECT_HI:`SECT_LO];
  assign idle      = ~in_progress_flag;
  assign exec_ok   = cs_rise & idle;
  assign otp_wr    = byte_done & (opcode == `OP_ONE_TIME_PROG) &
                     (byte_no >= 13'h0005) & write_enable_latch &
                     idle & ~otp_locked;

  // Frame decode and response loading
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bit_cnt <= 16'h0000;
      rx      <= 7'h00;
      opcode  <= 8'h00;
      addr    <= 32'h0000_0000;
      wbuf    <= 16'hFFFF;
      ptr     <= 11'h000;
      tx      <= 8'hFF;
      otp_err <= 1'b0;
    end else if (!cs_low) begin
      bit_cnt <= 16'h0000;
      otp_err <= 1'b0;
    end else if (sck_rise) begin
      bit_cnt <= next_cnt;
      rx      <= byte_val[6:0];
      if (byte_done && byte_no == 13'h0001) begin
        opcode <= byte_val;
        tx     <= 8'hFF;
        if (byte_val == `OP_STATUS_READ) begin
          tx <= status_byte(in_progress_flag, write_enable_latch,
                            program_error);
        end else if (byte_val == `OP_CONFIG_READ && idle) begin
          tx <= protect_config_register[7:0];
        end
      end else if (byte_done) begin
        if (byte_no <= 13'h0005) begin
          addr <= {addr[23:0], byte_val};
        end
        case (opcode)
          `OP_STATUS_READ: begin
            tx <= status_byte(in_progress_flag, write_enable_latch,
                              program_error);
          end
          `OP_CONFIG_READ: begin
            if (idle) begin
              tx <= byte_no[0] ? protect_config_register[7:0]
                               : protect_config_register[15:8];
            end
          end
          `OP_ONE_TIME_READ: begin
            if (byte_no == 13'h0004) begin
              ptr <= {1'b0, addr[1:0], byte_val};
            end else if (byte_no >= 13'h0005 && idle) begin
              tx <= ptr[10] ? 8'hFF : otp_mem[ptr[9:0]];
              if (!ptr[10]) begin
                ptr <= ptr + 11'h001;
              end
            end
          end
          `OP_ONE_TIME_PROG: begin
            if (byte_no == 13'h0004) begin
              ptr <= {1'b0, addr[1:0], byte_val};
            end else if (byte_no >= 13'h0005) begin
              ptr <= {1'b0, ptr[9:0] + 10'h001};
              if (otp_locked && byte_val != 8'hFF) begin
                otp_err <= 1'b1;
              end
            end
          end
          `OP_DYN_READ, `OP_PERS_READ: begin
            if (byte_no >= 13'h0005 && idle) begin
              tx <= lock_byte((opcode == `OP_DYN_READ)
                              ? dynamic_sector_lock[sect_now]
                              : persistent_sector_lock[sect_now]);
            end
          end
          `OP_CONFIG_PROG: begin
            if (byte_no == 13'h0002) begin
              wbuf[7:0] <= byte_val;
            end else if (byte_no == 13'h0003) begin
              wbuf[15:8] <= byte_val;
            end
          end
          `OP_DYN_WRITE: begin
            if (byte_no == 13'h0006) begin
              wbuf[7:0] <= byte_val;
            end
          end
          default: begin
          end
        endcase
      end
    end else if (sck_fall) begin
      tx <= {tx[6:0], 1'b1};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      miso_q <= 1'b0;
    end else if (cs_low && sck_fall) begin
      miso_q <= tx[7];
    end
  end
  assign link.miso = miso_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < `OTP_BYTES; i++) begin
        otp_mem[i] <= 8'hFF;
      end
    end else if (otp_wr) begin
      otp_mem[ptr[9:0]] <= otp_mem[ptr[9:0]] & byte_val;
    end
  end

  // Status, protection state and timed operations
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      in_progress_flag        <= 1'b0;
      write_enable_latch      <= 1'b0;
      program_error           <= 1'b0;
      protect_config_register <= `CONFIG_RESET;
      busy_cnt                <= 16'h0000;
      erasing                 <= 1'b0;
      dynamic_sector_lock     <= '1;
      persistent_sector_lock  <= '1;
    end else if (in_progress_flag) begin
      if (busy_cnt == 16'h0001) begin
        in_progress_flag   <= 1'b0;
        write_enable_latch <= 1'b0;
        erasing            <= 1'b0;
        if (erasing) begin
          persistent_sector_lock <= '1;
        end
      end
      busy_cnt <= busy_cnt - 16'h0001;
    end else if (exec_ok) begin
      case (opcode)
        `OP_WRITE_ENABLE: begin
          if (bit_cnt == `BITS_ONE_BYTE) begin
            write_enable_latch <= 1'b1;
          end
        end
        `OP_CLEAR_STATUS: begin
          if (bit_cnt == `BITS_ONE_BYTE) begin
            program_error <= 1'b0;
          end
        end
        `OP_ONE_TIME_PROG: begin
          if (write_enable_latch && bit_cnt[2:0] == 3'h0 &&
              bit_cnt >= `BITS_PERS_PROG) begin
            in_progress_flag <= 1'b1;
            busy_cnt         <= `PROG_CYCLES;
            if (otp_err) begin
              program_error <= 1'b1;
            end
          end
        end
        `OP_CONFIG_PROG: begin
          if (write_enable_latch && bit_cnt == `BITS_CONFIG_PROG) begin
            protect_config_register <= protect_config_register & wbuf;
            in_progress_flag        <= 1'b1;
            busy_cnt                <= `PROG_CYCLES;
          end
        end
        `OP_DYN_WRITE: begin
          if (write_enable_latch && bit_cnt == `BITS_DYN_WRITE) begin
            dynamic_sector_lock[addr[`SECT_HI:`SECT_LO]] <=
              (wbuf[7:0] == 8'hFF);
            in_progress_flag <= 1'b1;
            busy_cnt         <= `PROG_CYCLES;
          end
        end
        `OP_PERS_PROG: begin
          if (write_enable_latch && bit_cnt == `BITS_PERS_PROG) begin
            persistent_sector_lock[addr[`SECT_HI:`SECT_LO]] <= 1'b0;
            in_progress_flag <= 1'b1;
            busy_cnt         <= `PROG_CYCLES;
          end
        end
        `OP_PERS_ERASE: begin
          if (write_enable_latch && bit_cnt == `BITS_ONE_BYTE) begin
            persistent_sector_lock <= '0;
            erasing                <= 1'b1;
            in_progress_flag       <= 1'b1;
            busy_cnt               <= `ERASE_CYCLES;
          end
        end
        default: begin
        end
      endcase
    end
  end
endmodule

// file: hw/flash_protect_host.sv
// Purpose: Serial host driven from Avalon-MM registers
// Assumes: Device oversamples the link with its own clock
// Notes:   Up to 8 bytes sent and 2 bytes received per frame
`timescale 1ns/1ps
`include "link_map.svh"
module flash_protect_host
  import link_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [1:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  spi_link_if.host         link
);
  host_state_t state;
  logic [31:0] cmd;
  logic [31:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        busy;
  logic [3:0]  div;
  logic        tick;
  logic [63:0] sr;
  logic [6:0]  bit_cnt;
  logic [6:0]  tx_bits;
  logic [6:0]  tot_bits;
  logic [15:0] rd_sr;
  logic [1:0]  miso_s;
  logic        cs_q;
  logic        sck_q;
  logic        mosi_q;
  logic        start;
  logic [2:0]  ab;
  logic [1:0]  wb;
  logic [1:0]  rb;
  logic        dm;

  function automatic logic [63:0] build(input logic [7:0]  op,
                                        input logic [31:0] a,
                                        input logic [2:0]  nab,
                                        input logic [15:0] wd,
                                        input logic [1:0]  nwb);
    logic [63:0] f;
    f = {op, 56'h0000_0000_0000_00};
    for (int i = 0; i < 4; i++) begin
      if (i < int'(nab)) begin
        f[55 - 8 * i -: 8] = a[8 * (int'(nab) - 1 - i) +: 8];
      end
    end
    for (int j = 0; j < 2; j++) begin
      if (j < int'(nwb)) begin
        f[55 - 8 * (int'(nab) + j) -: 8] = wd[8 * j +: 8];
      end
    end
    build = f;
  endfunction

  assign ab    = cmd[`CMD_ABYTES_LSB +: 3];
  assign wb    = cmd[`CMD_WBYTES_LSB +: 2];
  assign rb    = cmd[`CMD_RBYTES_LSB +: 2];
  assign dm    = cmd[`CMD_DUMMY_BIT];
  assign tick  = (div == `SCK_HALF - 4'h1);
  assign start = avs_write & ~avs_waitrequest &
                 (avs_address == `REG_CMD) & ~busy;

  // Avalon slave, one wait cycle per access
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      cmd             <= 32'h0000_0000;
      addr            <= 32'h0000_0000;
      wdata           <= 16'h0000;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        case (avs_address)
          `REG_CMD:    avs_readdata <= cmd;
          `REG_ADDR:   avs_readdata <= addr;
          `REG_WDATA:  avs_readdata <= {16'h0000, wdata};
          `REG_STATUS: avs_readdata <= {busy, 15'h0000, rdata};
          default:     avs_readdata <= 32'h0000_0000;
        endcase
      end
      if (avs_write && !avs_waitrequest && !busy) begin
        case (avs_address)
          `REG_CMD:   cmd   <= avs_writedata;
          `REG_ADDR:  addr  <= avs_writedata;
          `REG_WDATA: wdata <= avs_writedata[15:0];
          default: begin
          end
        endcase
      end
    end
  end

  // Data-in synchroniser
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      miso_s <= 2'b00;
    end else begin
      miso_s <= {miso_s[0], link.miso};
    end
  end

  // Serial clock divider
  always_ff @(posedge clk) begin
    if (!rst_n || state == H_IDLE || tick) begin
      div <= 4'h0;
    end else begin
      div <= div + 4'h1;
    end
  end

  // Frame sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state    <= H_IDLE;
      busy     <= 1'b0;
      cs_q     <= 1'b1;
      sck_q    <= 1'b0;
      mosi_q   <= 1'b0;
      sr       <= 64'h0000_0000_0000_0000;
      bit_cnt  <= 7'h00;
      tx_bits  <= 7'h00;
      tot_bits <= 7'h00;
      rd_sr    <= 16'h0000;
      rdata    <= 16'h0000;
    end else begin
      case (state)
        H_IDLE: begin
          if (start) begin
            busy     <= 1'b1;
            cs_q     <= 1'b0;
            bit_cnt  <= 7'h00;
            rd_sr    <= 16'h0000;
            sr       <= build(avs_writedata[7:0], addr,
                              avs_writedata[`CMD_ABYTES_LSB +: 3],
                              wdata,
                              avs_writedata[`CMD_WBYTES_LSB +: 2]);
            mosi_q   <= avs_writedata[7];
            state    <= H_LEAD;
          end
        end
        H_LEAD: begin
          tx_bits  <= {4'h1 + {1'b0, ab} + {2'b00, wb} + {3'b000, dm},
                       3'h0};
          tot_bits <= {4'h1 + {1'b0, ab} + {2'b00, wb} + {3'b000, dm} +
                       {2'b00, rb}, 3'h0};
          if (tick) begin
            state <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (tick && !sck_q) begin
            sck_q   <= 1'b1;
            bit_cnt <= bit_cnt + 7'h01;
            if (bit_cnt >= tx_bits) begin
              rd_sr <= {rd_sr[14:0], miso_s[1]};
            end
          end else if (tick) begin
            sck_q <= 1'b0;
            if (bit_cnt == tot_bits) begin
              state <= H_TAIL;
            end else begin
              sr     <= {sr[62:0], 1'b0};
              mosi_q <= sr[62];
            end
          end
        end
        H_TAIL: begin
          if (tick) begin
            cs_q  <= 1'b1;
            state <= H_GAP;
          end
        end
        H_GAP: begin
          if (tick) begin
            rdata <= (rb == 2'h2) ? {rd_sr[7:0], rd_sr[15:8]}
                                  : {8'h00, rd_sr[7:0]};
            busy  <= 1'b0;
            state <= H_IDLE;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

  assign link.cs_n = cs_q;
  assign link.sck  = sck_q;
  assign link.mosi = mosi_q;
endmodule

// file: sim/link_protocol_sva.sv
// Purpose: Link and flag checks
// Assumes: Flags sampled on clk
// Notes:   Instanced beside the link
`timescale 1ns/1ps
module link_protocol_sva (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        cs_n,
  input wire logic        sck,
  input wire logic        mosi,
  input wire logic        miso,
  input wire logic        in_progress_flag,
  input wire logic        write_enable_latch,
  input wire logic        program_error,
  input wire logic [15:0] protect_config_register
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_MISO_ON_FALL: assert property ($changed(miso) |-> !sck)
    else $error("miso moved while sck high");
  AST_MOSI_HELD: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("mosi moved while sck high");
  AST_SCK_IDLE: assert property (cs_n |-> !sck)
    else $error("sck high outside frame");
  AST_BUSY_AT_CS: assert property ($rose(in_progress_flag) |-> cs_n)
    else $error("busy rose inside frame");
  AST_BUSY_ENDS: assert property
    ($rose(in_progress_flag) |-> ##[19:120] !in_progress_flag)
    else $error("busy did not end");
  AST_BUSY_MIN: assert property
    ($rose(in_progress_flag) |-> in_progress_flag [*8])
    else $error("busy too short");
  AST_NEEDS_LATCH: assert property
    ($rose(in_progress_flag) |-> $past(write_enable_latch))
    else $error("timed op without latch");
  AST_LATCH_CLR: assert property
    ($fell(in_progress_flag) |-> !write_enable_latch)
    else $error("latch kept after op");
  AST_CFG_PROG: assert property ($changed(protect_config_register) |->
    cs_n && (protect_config_register
    & ~$past(protect_config_register)) == 16'h0000)
    else $error("config changed wrongly");
  AST_ERR_AT_CS: assert property ($rose(program_error) |-> cs_n)
    else $error("error rose inside frame");
  cover property ($rose(in_progress_flag));
  cover property ($rose(program_error));
  cover property ($changed(protect_config_register));
endmodule

// file: sim/test_otp_and_sector_protection_cmds.sv
// Purpose: Drives host registers, checks flash end
// Assumes: Host and device joined by spi_link_if
// Notes:   Expected values from command semantics
`timescale 1ns/1ps
`include "link_map.svh"
module test_otp_and_sector_protection_cmds;
  logic        clk;
  logic        rst_n;
  logic        otp_locked;
  logic [1:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        in_progress_flag;
  logic        write_enable_latch;
  logic        program_error;
  logic [15:0] protect_config_register;
  logic [15:0] rd;
  int          n_errors;
  int          tests_run;
  int          cycles;
  spi_link_if lk();
  flash_protect_device flash_protect_device_i (.clk(clk), .rst_n(rst_n),
    .otp_locked(otp_locked), .link(lk.device),
    .in_progress_flag(in_progress_flag),
    .write_enable_latch(write_enable_latch),
    .program_error(program_error),
    .protect_config_register(protect_config_register));
  flash_protect_host flash_protect_host_i (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .link(lk.host));
  link_protocol_sva link_protocol_sva_i (.clk(clk), .rst_n(rst_n),
    .cs_n(lk.cs_n), .sck(lk.sck), .mosi(lk.mosi), .miso(lk.miso),
    .in_progress_flag(in_progress_flag),
    .write_enable_latch(write_enable_latch),
    .program_error(program_error),
    .protect_config_register(protect_config_register));
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic av(input logic wr, input logic [1:0] ad,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_address <= ad;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic frame(input logic [7:0] op, input logic [31:0] a,
    input logic [2:0] nab, input logic [15:0] wd, input logic [1:0] nwb,
    input logic [1:0] nrb, input logic dmy);
    logic [31:0] q;
    av(1'b1, `REG_ADDR, a, q);
    av(1'b1, `REG_WDATA, {16'h0000, wd}, q);
    av(1'b1, `REG_CMD,
       {11'h000, dmy, 2'h0, nrb, 2'h0, nwb, 1'b0, nab, op}, q);
    do begin
      av(1'b0, `REG_STATUS, 32'h0000_0000, q);
    end while (q[31] !== 1'b0);
    rd = q[15:0];
  endtask
  task automatic settle;
    int n = 0;
    while (in_progress_flag !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    check("busy end", in_progress_flag, 1'b0);
  endtask
  task automatic enable_writes;
    frame(`OP_WRITE_ENABLE, '0, '0, '0, '0, '0, 1'b0);
  endtask
  task automatic prog(input logic [31:0] a, input logic [15:0] wd);
    enable_writes();
    frame(`OP_ONE_TIME_PROG, a, 3'h3, wd, 2'h2, '0, 1'b0);
    settle();
  endtask
  task automatic t_config;
    frame(`OP_CONFIG_READ, '0, '0, '0, '0, 2'h2, 1'b0);
    check("cfg read", rd, 16'hFFFF);
    frame(`OP_CONFIG_PROG, '0, '0, 16'hA5F0, 2'h2, '0, 1'b0);
    check("cfg unlatched", protect_config_register, 16'hFFFF);
    enable_writes();
    frame(`OP_CONFIG_PROG, '0, '0, 16'h5AF0, 2'h1, '0, 1'b0);
    check("cfg short", protect_config_register, 16'hFFFF);
    check("latch kept", write_enable_latch, 1'b1);
    frame(`OP_CONFIG_PROG, '0, '0, 16'hA5F0, 2'h2, '0, 1'b0);
    check("cfg busy", in_progress_flag, 1'b1);
    settle();
    check("latch clear", write_enable_latch, 1'b0);
    frame(`OP_CONFIG_READ, '0, '0, '0, '0, 2'h2, 1'b0);
    check("cfg order", rd, 16'hA5F0);
  endtask
  task automatic t_dyn;
    frame(`OP_DYN_READ, 32'h0014_0000, 3'h4, '0, '0, 2'h2, 1'b0);
    check("dyn open", rd, 16'hFFFF);
    enable_writes();
    frame(`OP_DYN_WRITE, 32'h0014_0000, 3'h4, '0, 2'h1, '0, 1'b0);
    settle();
    check("dyn latch", write_enable_latch, 1'b0);
    frame(`OP_DYN_READ, 32'h0014_0000, 3'h4, '0, '0, 2'h2, 1'b0);
    check("dyn lock", rd, 16'h0000);
    enable_writes();
    frame(`OP_DYN_WRITE, 32'h0018_0000, 3'h4, '0, 2'h2, '0, 1'b0);
    frame(`OP_DYN_READ, 32'h0018_0000, 3'h4, '0, '0, 2'h2, 1'b0);
    check("dyn long", rd, 16'hFFFF);
  endtask
  task automatic t_pers;
    frame(`OP_PERS_PROG, 32'h0014_0000, 3'h4, '0, 2'h1, '0, 1'b0);
    check("pers long", write_enable_latch, 1'b1);
    frame(`OP_PERS_PROG, 32'h0014_0000, 3'h4, '0, '0, '0, 1'b0);
    settle();
    frame(`OP_PERS_READ, 32'h0014_0000, 3'h4, '0, '0, 2'h2, 1'b0);
    check("pers lock", rd, 16'h0000);
    frame(`OP_PERS_READ, 32'h0018_0000, 3'h4, '0, '0, 2'h2, 1'b0);
    check("pers other", rd, 16'hFFFF);
    frame(`OP_PERS_ERASE, '0, '0, '0, '0, '0, 1'b0);
    check("erase unlatched", in_progress_flag, 1'b0);
    enable_writes();
    frame(`OP_PERS_ERASE, '0, '0, 16'hFFFF, 2'h1, '0, 1'b0);
    check("erase long", in_progress_flag, 1'b0);
    frame(`OP_PERS_ERASE, '0, '0, '0, '0, '0, 1'b0);
    check("erase busy", in_progress_flag, 1'b1);
    settle();
    frame(`OP_PERS_READ, 32'h0014_0000, 3'h4, '0, '0, 2'h2, 1'b0);
    check("erase all", rd, 16'hFFFF);
  endtask
  task automatic t_one_time;
    frame(`OP_ONE_TIME_PROG, 32'h0000_0010, 3'h3, 16'hA55A, 2'h2, '0, 1'b0);
    frame(`OP_ONE_TIME_READ, 32'h0000_0010, 3'h3, '0, '0, 2'h2, 1'b1);
    check("ot unlatched", rd, 16'hFFFF);
    prog(32'h0000_0010, 16'hA55A);
    prog(32'h0000_0010, 16'h0FF0);
    frame(`OP_ONE_TIME_READ, 32'h0000_0010, 3'h3, '0, '0, 2'h2, 1'b1);
    check("ot and", rd, 16'h0550);
    prog(32'h0000_0010, 16'hFFEF);
    frame(`OP_ONE_TIME_READ, 32'h0000_0010, 3'h3, '0, '0, 2'h2, 1'b1);
    check("ot single bit", rd, 16'h0540);
    prog(32'h0000_03FF, 16'h1200);
    frame(`OP_ONE_TIME_READ, 32'h0000_03FF, 3'h3, '0, '0, 2'h2, 1'b1);
    check("ot top", rd, 16'hFF00);
  endtask
  task automatic t_locked;
    otp_locked <= 1'b1;
    prog(32'h0000_0020, 16'hFFFF);
    check("ones no error", program_error, 1'b0);
    prog(32'h0000_0020, 16'h00FF);
    check("zeros error", program_error, 1'b1);
    frame(`OP_ONE_TIME_READ, 32'h0000_0020, 3'h3, '0, '0, 2'h2, 1'b1);
    check("locked kept", rd, 16'hFFFF);
    frame(`OP_STATUS_READ, '0, '0, '0, '0, 2'h1, 1'b0);
    check("status error", rd, 16'h0040);
    frame(`OP_CLEAR_STATUS, '0, '0, '0, '0, '0, 1'b0);
    check("error cleared", program_error, 1'b0);
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    otp_locked = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    n_errors = 0;
    tests_run = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_config();
    t_dyn();
    t_pers();
    t_one_time();
    t_locked();
    final_report();
  end
  always #50 clk = ~clk;
  initial cycles = 0;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_errors++;
      final_report();
    end
  end
endmodule
